// ===== hw/ncm_consts.vh
// constants shared by the oscillator mixer datapath
`ifndef NCM_CONSTS_VH
`define NCM_CONSTS_VH

// sample and oscillator word widths
`define NCM_SAMPLE_W    16
`define NCM_FREQ_W      32
`define NCM_OFFSET_W    16
`define NCM_SEL_W       4

// oscillator accumulator reset value
`define NCM_ACC_RESET   32'h0000_0000
// low zero bits padding the offset up to accumulator width
`define NCM_OFFSET_PAD  16'h0000

// sine table phase resolution (bits of phase used for lookup)
`define NCM_LUT_BITS    6
// index of the quarter-wave entry for ninety degrees
`define NCM_QUARTER     5'h10
// cosine leads sine by a quarter turn in lookup phase
`define NCM_COS_SHIFT   6'h10
// coarse fs/8 step as a shift: eight lookup units, one eighth turn
`define NCM_FS8_STEP    3'h3

// fractional bits of the table amplitude
`define NCM_FRAC        15
`define NCM_FRAC_HALF   16

// coarse mixer select bit positions
`define NCM_CMIX_FS8    3
`define NCM_CMIX_FS4    2
`define NCM_CMIX_FS2    1
`define NCM_CMIX_NFS4   0

// signed sample range limits
`define NCM_SAT_MAX     16'h7FFF
`define NCM_SAT_MIN     16'h8000

`endif

// ===== hw/ncm_fifo.v
// small sample fifo with valid/ready on both sides
`timescale 1ns/1ps
module ncm_fifo #(
  parameter WIDTH  = 32,
  parameter DEPTH  = 4,
  parameter ADDR_W = 2
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  localparam [ADDR_W:0] FULL_CNT = DEPTH;

  reg [WIDTH-1:0]  mem [0:DEPTH-1];  // entry storage
  reg [ADDR_W-1:0] wrPtr_q;          // write pointer
  reg [ADDR_W-1:0] rdPtr_q;          // read pointer
  reg [ADDR_W:0]   count_q;          // words held
  reg [ADDR_W:0]   count_d;
  reg              ready_q;          // registered not-full

  wire push = inValid & ready_q;
  wire pop  = outValid & outReady;

  assign inReady  = ready_q;
  assign outValid = (count_q != {(ADDR_W+1){1'b0}});
  assign outData  = mem[rdPtr_q];

  // occupancy next value
  always @* begin
    count_d = count_q;
    if (push & ~pop)
      count_d = count_q + 1'b1;
    else if (pop & ~push)
      count_d = count_q - 1'b1;
  end

  // storage write, no reset needed on data
  always @(posedge clk_sys) begin
    if (push)
      mem[wrPtr_q] <= inData;
  end

  // pointers, count and ready flag
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wrPtr_q <= {ADDR_W{1'b0}};
      rdPtr_q <= {ADDR_W{1'b0}};
      count_q <= {(ADDR_W+1){1'b0}};
      ready_q <= 1'b0;
    end else begin
      if (push)
        wrPtr_q <= (wrPtr_q == DEPTH - 1) ? {ADDR_W{1'b0}} : wrPtr_q + 1'b1;
      if (pop)
        rdPtr_q <= (rdPtr_q == DEPTH - 1) ? {ADDR_W{1'b0}} : rdPtr_q + 1'b1;
      count_q <= count_d;
      ready_q <= (count_d != FULL_CNT);
    end
  end
endmodule

// ===== hw/ncm_mixer.v
// complex mixer: oscillator, complex multiplier and coarse mixer
`timescale 1ns/1ps
`include "ncm_consts.vh"
module ncm_mixer #(
  parameter FIFO_DEPTH  = 4,
  parameter FIFO_ADDR_W = 2
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        inValid,
  output wire        inReady,
  input  wire [15:0] inI,
  input  wire [15:0] inQ,
  output wire        outValid,
  input  wire        outReady,
  output wire [15:0] outI,
  output wire [15:0] outQ,
  input  wire        fullMixEnable,
  input  wire [31:0] freqWord,
  input  wire [15:0] phaseOffset,
  input  wire        mixerGain,
  input  wire [3:0]  coarseSel,
  input  wire [3:0]  oscSyncSourceSel,
  input  wire [3:0]  syncSources
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [`NCM_FREQ_W-1:0]    acc_q;        // oscillator phase accumulator
  reg  [2:0]                smpCnt_q;     // coarse sequence sample index
  reg                       outValid_q;   // output sample held
  reg  [`NCM_SAMPLE_W-1:0]  outI_q;       // output real part
  reg  [`NCM_SAMPLE_W-1:0]  outQ_q;       // output imaginary part

  wire                      fifoValid;    // head sample present
  wire [2*`NCM_SAMPLE_W-1:0] fifoData;    // head sample {I,Q}
  wire                      fire;         // head sample consumed
  wire                      syncEvent;    // selected sync source fired

  wire [`NCM_FREQ_W-1:0]    theta;        // accumulator plus offset
  reg  [`NCM_LUT_BITS-1:0]  lutPhase;     // phase into lookup
  wire signed [15:0]        sinT;         // sine term
  wire signed [15:0]        cosT;         // cosine term

  wire signed [15:0]        smpI;         // head real part
  wire signed [15:0]        smpQ;         // head imaginary part
  wire signed [31:0]        pIc;          // I times cos
  wire signed [31:0]        pQs;          // Q times sin
  wire signed [31:0]        pIs;          // I times sin
  wire signed [31:0]        pQc;          // Q times cos
  wire signed [32:0]        sumRe;        // unscaled real result
  wire signed [32:0]        sumIm;        // unscaled imaginary result
  wire signed [32:0]        scRe;         // gain-scaled real result
  wire signed [32:0]        scIm;         // gain-scaled imaginary result

  wire                      useMult;      // multiplier in the path
  reg  [15:0]               multI;        // multiplier stage real out
  reg  [15:0]               multQ;        // multiplier stage imag out
  reg  [1:0]                quarterTurns; // coarse rotation amount
  reg  [15:0]               mixI;         // coarse stage real out
  reg  [15:0]               mixQ;         // coarse stage imag out

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // both helpers clip rather than wrap, so a
  // full-scale rotation never flips sign
  // clamp a wide signed value into sample range
  function [15:0] sat16;
    input signed [32:0] v;
    begin
      if (v > $signed({{17{1'b0}}, `NCM_SAT_MAX}))
        sat16 = `NCM_SAT_MAX;
      else if (v < $signed({{17{1'b1}}, `NCM_SAT_MIN}))
        sat16 = `NCM_SAT_MIN;
      else
        sat16 = v[15:0];
    end
  endfunction

  // negate with the most negative code clamped
  function [15:0] neg16;
    input [15:0] x;
    begin
      if (x == `NCM_SAT_MIN)
        neg16 = `NCM_SAT_MAX;
      else
        neg16 = 16'h0000 - x;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // input buffering

  // the fifo absorbs bursts from the upstream
  // stages; its ready is registered, so the
  // source sees no combinational path to the
  // output stall
  // fifo takes paired samples from the interpolation stages
  ncm_fifo #(
    .WIDTH  (2*`NCM_SAMPLE_W),
    .DEPTH  (FIFO_DEPTH),
    .ADDR_W (FIFO_ADDR_W)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inValid  (inValid),
    .inReady  (inReady),
    .inData   ({inI, inQ}),
    .outValid (fifoValid),
    .outReady (fire),
    .outData  (fifoData)
  );

  // head advances when the output slot is free or draining
  assign fire = fifoValid & (~outValid_q | outReady);

  // first channel is the real part, second the imaginary
  assign smpI = fifoData[2*`NCM_SAMPLE_W-1:`NCM_SAMPLE_W];
  assign smpQ = fifoData[`NCM_SAMPLE_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // oscillator

  // sync outranks the step: a cleared phase is
  // seen by the next sample, and a sync held for
  // several clocks pins the phase at zero
  // any selected source that fires counts as a sync event
  assign syncEvent = |(syncSources & oscSyncSourceSel);

  // accumulate every clock, wrap modulo 2^32, clear on sync
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_q <= `NCM_ACC_RESET;
    end else if (syncEvent) begin
      acc_q <= `NCM_ACC_RESET;
    end else begin
      acc_q <= acc_q + freqWord;
    end
  end

  // offset word sits at the top, so it spans one full turn
  assign theta = acc_q + {phaseOffset, `NCM_OFFSET_PAD};

  ////////////////////////////////////////////////////////////////////////////
  // coarse sample sequence

  // the index moves per sample, not per clock,
  // so stalls do not skip coarse sequence steps
  // sample index counts consumed samples, restarts on sync
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      smpCnt_q <= 3'h0;
    end else if (syncEvent) begin
      smpCnt_q <= 3'h0;
    end else if (fire) begin
      smpCnt_q <= smpCnt_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sine/cosine terms

  // only the top lookup bits are used: finer
  // phase steps are traded for a small table
  // fs/8 moves eight lookup steps per sample
  // full mixer uses oscillator phase, fs/8 uses fixed steps
  always @* begin
    if (fullMixEnable)
      lutPhase = theta[`NCM_FREQ_W-1:`NCM_FREQ_W-`NCM_LUT_BITS];
    else
      lutPhase = {3'h0, smpCnt_q} << `NCM_FS8_STEP;
  end

  ncm_sincos u_sincos (
    .phase  (lutPhase),
    .sinOut (sinT),
    .cosOut (cosT)
  );

  ////////////////////////////////////////////////////////////////////////////
  // complex multiplier

  // products keep full width; the sum gets one
  // guard bit so the worst-case rotation of two
  // full-scale terms cannot overflow before
  // the scaling shift and the clamp
  // four partial products of the rotation
  assign pIc = smpI * cosT;
  assign pQs = smpQ * sinT;
  assign pIs = smpI * sinT;
  assign pQc = smpQ * cosT;

  // real = I cos - Q sin, imag = I sin + Q cos
  assign sumRe = {pIc[31], pIc} - {pQs[31], pQs};
  assign sumIm = {pIs[31], pIs} + {pQc[31], pQc};

  // the shift floors, so negative results
  // round away from zero by at most one code
  // gain one keeps unit scale, gain zero halves it
  assign scRe = mixerGain ? (sumRe >>> `NCM_FRAC) : (sumRe >>> `NCM_FRAC_HALF);
  assign scIm = mixerGain ? (sumIm >>> `NCM_FRAC) : (sumIm >>> `NCM_FRAC_HALF);

  // multiplier used by full mixer or by the fs/8 stage
  assign useMult = fullMixEnable | coarseSel[`NCM_CMIX_FS8];

  // with the multiplier idle no scaling applies
  // bypass passes samples untouched when multiplier is idle
  always @* begin
    if (useMult) begin
      multI = sat16(scRe);
      multQ = sat16(scIm);
    end else begin
      multI = smpI;
      multQ = smpQ;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // coarse negate/swap stages

  // swaps follow the multiplier, so they also
  // act on a rotated or fs/8 sample; combined
  // stages add their quarter turns modulo four
  // each enabled stage adds its quarter turns per sample
  always @* begin
    quarterTurns = 2'h0;
    if (coarseSel[`NCM_CMIX_FS4])
      quarterTurns = quarterTurns + smpCnt_q[1:0];
    if (coarseSel[`NCM_CMIX_FS2])
      quarterTurns = quarterTurns + {smpCnt_q[0], 1'b0};
    if (coarseSel[`NCM_CMIX_NFS4])
      quarterTurns = quarterTurns - smpCnt_q[1:0];
  end

  // rotation by quarter turns: no multiply, no gain
  always @* begin
    case (quarterTurns)
      2'h0: begin
        mixI = multI;
        mixQ = multQ;
      end
      2'h1: begin
        mixI = neg16(multQ);
        mixQ = multI;
      end
      2'h2: begin
        mixI = neg16(multI);
        mixQ = neg16(multQ);
      end
      2'h3: begin
        mixI = multQ;
        mixQ = neg16(multI);
      end
      default: begin
        mixI = multI;
        mixQ = multQ;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output register

  // the slot reloads in the cycle it drains,
  // so a ready consumer sees one pair per clock
  // one output slot, held until the consumer takes it
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      outValid_q <= 1'b0;
      outI_q     <= 16'h0000;
      outQ_q     <= 16'h0000;
    end else if (fire) begin
      outValid_q <= 1'b1;
      outI_q     <= mixI;
      outQ_q     <= mixQ;
    end else if (outReady) begin
      outValid_q <= 1'b0;
    end
  end

  assign outValid = outValid_q;
  assign outI     = outI_q;
  assign outQ     = outQ_q;

endmodule

// ===== hw/ncm_sincos.v
// quarter-wave sine and cosine lookup, Q15 amplitude
`timescale 1ns/1ps
`include "ncm_consts.vh"
module ncm_sincos (
  input  wire        [`NCM_LUT_BITS-1:0] phase,
  output wire signed [`NCM_SAMPLE_W-1:0] sinOut,
  output wire signed [`NCM_SAMPLE_W-1:0] cosOut
);
  // quarter-wave table, index 0..16 spans zero to ninety degrees
  function [15:0] quarterTab;
    input [4:0] k;
    begin
      case (k)
        5'h00: quarterTab = 16'h0000;
        5'h01: quarterTab = 16'h0C8C;
        5'h02: quarterTab = 16'h18F9;
        5'h03: quarterTab = 16'h2528;
        5'h04: quarterTab = 16'h30FB;
        5'h05: quarterTab = 16'h3C56;
        5'h06: quarterTab = 16'h471C;
        5'h07: quarterTab = 16'h5133;
        5'h08: quarterTab = 16'h5A82;
        5'h09: quarterTab = 16'h62F1;
        5'h0A: quarterTab = 16'h6A6D;
        5'h0B: quarterTab = 16'h70E2;
        5'h0C: quarterTab = 16'h7641;
        5'h0D: quarterTab = 16'h7A7C;
        5'h0E: quarterTab = 16'h7D89;
        5'h0F: quarterTab = 16'h7F61;
        default: quarterTab = 16'h7FFF;
      endcase
    end
  endfunction

  // full-circle sine from quadrant and in-quadrant index
  function [15:0] fullSin;
    input [5:0] p;
    reg   [15:0] mag;
    begin
      mag = 16'h0000;
      if (p[4])
        mag = quarterTab(`NCM_QUARTER - {1'b0, p[3:0]});
      else
        mag = quarterTab({1'b0, p[3:0]});
      fullSin = p[5] ? (16'h0000 - mag) : mag;
    end
  endfunction

  wire [`NCM_LUT_BITS-1:0] cosPhase = phase + `NCM_COS_SHIFT;

  assign sinOut = fullSin(phase);
  assign cosOut = fullSin(cosPhase);
endmodule

// ===== testbench/ncm_mixer_monitor.sv
// port-level assertion checker for the complex mixer
`timescale 1ns/1ps
module ncm_mixer_monitor (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        inValid,
  input wire        inReady,
  input wire        outValid,
  input wire        outReady,
  input wire [15:0] outI,
  input wire [15:0] outQ
);
  ////////////////////////////////////////////////////////////////////////////
  // helper: samples held in fifo plus output slot
  wire       take = inValid && inReady; // sample accepted
  wire       drop = outValid && outReady; // sample consumed
  reg  [2:0] cnt_q;                                        // samples held
  wire [2:0] cnt_d = cnt_q + {2'h0, take} - {2'h0, drop}; // next count
  // occupancy counter
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_n |=> !outValid && outI == 16'h0000 && outQ == 16'h0000)
    else $error("output not cleared by reset");
  a_ready_reset: assert property (disable iff (1'b0) !rst_n |=> !inReady)
    else $error("ready high during reset");
  a_ready_rise: assert property ($rose(rst_n) |=> inReady)
    else $error("ready late after reset");
  a_out_hold: assert property (
    outValid && !outReady |=> outValid && $stable(outI) && $stable(outQ))
    else $error("output pair changed while stalled");
  a_take_answer: assert property (take && cnt_q == 3'h0 |-> ##2 outValid)
    else $error("output not two cycles after take");
  a_no_overflow: assert property (cnt_q <= 3'h5)
    else $error("more samples held than storage");
  a_ready_full: assert property (cnt_q == 3'h5 |-> !inReady)
    else $error("ready while full");
  a_out_empty: assert property (outValid |-> cnt_q != 3'h0)
    else $error("output valid with nothing held");
  a_out_drop: assert property (drop && cnt_q == 3'h1 && !take |=> !outValid)
    else $error("output repeated after consume");
endmodule

bind ncm_mixer ncm_mixer_monitor i_ncm_mixer_monitor (
  .clk_sys  (clk_sys),
  .rst_n    (rst_n),
  .inValid  (inValid),
  .inReady  (inReady),
  .outValid (outValid),
  .outReady (outReady),
  .outI     (outI),
  .outQ     (outQ)
);

// ===== testbench/ncm_mixer_tb.sv
// self-checking bench for the complex mixer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked = checked + 1; if ((g) !== (e)) begin \
  n_errors = n_errors + 1; $display("FAIL %s exp %h got %h", nm, e, g); end end
module ncm_mixer_tb;
  reg         clk_sys, rst_n, outReady, fullMixEnable, mixerGain;
  reg  [31:0] freqWord;
  reg  [15:0] phaseOffset;
  reg  [3:0]  coarseSel, oscSyncSourceSel, syncSources;
  wire        inValid, inReady, outValid;
  wire [15:0] inI, inQ, outI, outQ;
  integer     n_errors, checked;
  reg  [31:0] got[$]; // consumed output pairs
  ////////////////////////////////////////////////////////////////////////////
  always #12.5 clk_sys = ~clk_sys;
  // collect every consumed pair
  always @(posedge clk_sys) begin
    if (outValid && outReady) got.push_back({outI, outQ});
  end
  ncm_mixer #(.FIFO_DEPTH(4), .FIFO_ADDR_W(2)) i_ncm_mixer (
    .clk_sys(clk_sys), .rst_n(rst_n), .inValid(inValid), .inReady(inReady),
    .inI(inI), .inQ(inQ), .outValid(outValid), .outReady(outReady),
    .outI(outI), .outQ(outQ), .fullMixEnable(fullMixEnable),
    .freqWord(freqWord), .phaseOffset(phaseOffset), .mixerGain(mixerGain),
    .coarseSel(coarseSel), .oscSyncSourceSel(oscSyncSourceSel),
    .syncSources(syncSources));
  ncm_src i_ncm_src (.clk_sys(clk_sys), .inReady(inReady), .inValid(inValid),
    .inI(inI), .inQ(inQ));
  ////////////////////////////////////////////////////////////////////////////
  // clamp to signed sample range
  function [15:0] sat(input signed [47:0] v);
    sat = (v > 48'sh7FFF) ? 16'h7FFF : (v < -48'sh8000) ? 16'h8000 : v[15:0];
  endfunction
  // sine of a multiple of an eighth turn, Q15
  function signed [17:0] oct(input [2:0] p);
    begin
      oct = (p[1:0] == 2'h0) ? 18'sh0 : (p[1:0] == 2'h2) ? 18'sh7FFF : 18'sh5A82;
      if (p[2]) oct = -oct;
    end
  endfunction
  // rotation at eighth-turn lookup phases
  function [31:0] rot(input [15:0] i, input [15:0] q, input [2:0] p, input g);
    reg signed [17:0] s, c;
    reg signed [47:0] re, im;
    begin
      s = oct(p);
      c = oct(p + 3'h2);
      re = ($signed(i) * c - $signed(q) * s) >>> (g ? 15 : 16);
      im = ($signed(i) * s + $signed(q) * c) >>> (g ? 15 : 16);
      rot = {sat(re), sat(im)};
    end
  endfunction
  // negate with clamp
  function [15:0] neg(input [15:0] x);
    neg = (x == 16'h8000) ? 16'h7FFF : -x;
  endfunction
  // coarse quarter-turn swap
  function [31:0] crot(input [15:0] i, input [15:0] q, input [1:0] r);
    crot = (r == 2'h0) ? {i, q} : (r == 2'h1) ? {neg(q), i} :
           (r == 2'h2) ? {neg(i), neg(q)} : {q, neg(i)};
  endfunction
  // wait for next consumed pair and compare
  task want(input [31:0] e);
    integer    n;
    reg [31:0] seen;
    begin
      n = 0;
      while (got.size() == 0 && n < 64) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      #1;
      seen = (got.size() != 0) ? got.pop_front() : 32'hXXXXXXXX;
      `CHK("pair", e, seen)
    end
  endtask
  task close_out;
    begin
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // no mixing: pairs pass unchanged
  task t_bypass;
    begin
      i_ncm_src.send(16'h8000, 16'h7FFF);
      i_ncm_src.send(16'h1234, 16'hFEDC);
      i_ncm_src.idle;
      want({16'h8000, 16'h7FFF});
      want({16'h1234, 16'hFEDC});
      $display("test bypass done");
    end
  endtask
  // offset quadrants at both gains
  task t_rotate;
    integer k;
    begin
      fullMixEnable = 1'b1;
      for (k = 0; k < 8; k = k + 1) begin
        phaseOffset = {k[1:0], 14'h0000};
        mixerGain = k[2];
        i_ncm_src.send(16'h4000, 16'hE000);
        i_ncm_src.idle;
        want(rot(16'h4000, 16'hE000, {k[1:0], 1'b0}, k[2]));
      end
      mixerGain = 1'b1;
      phaseOffset = 16'h0000;
      $display("test rotate done");
    end
  endtask
  // quarter turn per clock from each sync source, wrap on fifth
  task t_acc;
    integer b, k;
    begin
      freqWord = 32'h4000_0000;
      for (b = 0; b < 4; b = b + 1) begin
        oscSyncSourceSel = 4'h1 << b;
        syncSources = 4'h1 << b;
        for (k = 0; k < 5; k = k + 1) begin
          i_ncm_src.send(16'h2000, 16'h1000);
          syncSources = ~(4'h1 << b);
        end
        i_ncm_src.idle;
        for (k = 0; k < 5; k = k + 1)
          want(rot(16'h2000, 16'h1000, {k[1:0], 1'b0}, 1'b1));
      end
      freqWord = 32'h0000_0000;
      syncSources = 4'h0;
      $display("test accumulator done");
    end
  endtask
  // -fs/4, fs/2, fs/4 sequences after index restart
  task t_coarse;
    integer m, k;
    reg [1:0] kk;
    begin
      fullMixEnable = 1'b0;
      for (m = 0; m < 3; m = m + 1) begin
        coarseSel = 4'h1 << m;
        syncSources = oscSyncSourceSel;
        @(posedge clk_sys);
        #1;
        syncSources = 4'h0;
        for (k = 0; k < 4; k = k + 1) i_ncm_src.send(16'h8000, 16'h1234);
        i_ncm_src.idle;
        for (k = 0; k < 4; k = k + 1) begin
          kk = k[1:0];
          want(crot(16'h8000, 16'h1234,
            (m == 0) ? -kk : (m == 1) ? {kk[0], 1'b0} : kk));
        end
      end
      coarseSel = 4'h0;
      $display("test coarse done");
    end
  endtask
  // stall consumer until input refuses, then drain in order
  task t_full;
    integer k;
    begin
      outReady = 1'b0;
      for (k = 0; k < 5; k = k + 1) i_ncm_src.send({12'h000, k[3:0]}, 16'h00A5);
      i_ncm_src.idle;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("ready when full", 1'b0, inReady)
      `CHK("valid when stalled", 1'b1, outValid)
      outReady = 1'b1;
      for (k = 0; k < 5; k = k + 1) want({12'h000, k[3:0], 16'h00A5});
      $display("test full done");
    end
  endtask
  // fs/8 steps an eighth turn per sample, full scale clips
  task t_fs8;
    integer k;
    begin
      fullMixEnable = 1'b0;
      coarseSel = 4'h8;
      syncSources = oscSyncSourceSel;
      @(posedge clk_sys);
      #1;
      syncSources = 4'h0;
      for (k = 0; k < 8; k = k + 1) i_ncm_src.send(16'h7FFF, 16'h8000);
      i_ncm_src.idle;
      for (k = 0; k < 8; k = k + 1)
        want(rot(16'h7FFF, 16'h8000, k[2:0], 1'b1));
      coarseSel = 4'h0;
      $display("test fs8 done");
    end
  endtask
  // reset in mid-run drops the held pair and restarts
  task t_rerun;
    begin
      outReady = 1'b0;
      i_ncm_src.send(16'h0123, 16'h4567);
      i_ncm_src.idle;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("valid before reset", 1'b1, outValid)
      rst_n = 1'b0;
      @(posedge clk_sys);
      #1;
      `CHK("valid in reset", 1'b0, outValid)
      `CHK("pair in reset", 32'h0000_0000, {outI, outQ})
      `CHK("ready in reset", 1'b0, inReady)
      rst_n = 1'b1;
      outReady = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("ready after reset", 1'b1, inReady)
      `CHK("valid after reset", 1'b0, outValid)
      $display("test reset in run done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    outReady = 1'b1;
    fullMixEnable = 1'b0;
    freqWord = 32'h0000_0000;
    phaseOffset = 16'h0000;
    mixerGain = 1'b1;
    coarseSel = 4'h0;
    oscSyncSourceSel = 4'h1;
    syncSources = 4'h0;
    n_errors = 0;
    checked = 0;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("ready in reset", 1'b0, inReady)
    `CHK("valid in reset", 1'b0, outValid)
    rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK("ready after reset", 1'b1, inReady)
    $display("test reset done");
    t_bypass;
    t_rotate;
    t_acc;
    t_coarse;
    t_fs8;
    t_full;
    t_rerun;
    close_out;
  end
  // watchdog: about thirty times the expected run
  initial begin
    #100000;
    n_errors = n_errors + 1;
    close_out;
  end
endmodule

// ===== testbench/ncm_src.sv
// upstream sample source model feeding paired samples
`timescale 1ns/1ps
module ncm_src (
  input  wire        clk_sys,
  input  wire        inReady,
  output reg         inValid,
  output reg  [15:0] inI,
  output reg  [15:0] inQ
);
  // idle at time zero
  initial begin
    inValid = 1'b0;
    inI = 16'h0000;
    inQ = 16'h0000;
  end
  // offer one pair, hold until an edge sees ready
  task send(input [15:0] i, input [15:0] q);
    reg     r;
    integer n;
    begin
      inI = i;
      inQ = q;
      inValid = 1'b1;
      r = 1'b0;
      n = 0;
      while (!r && n < 64) begin
        r = inReady;
        @(posedge clk_sys);
        n = n + 1;
      end
      #1;
    end
  endtask
  // release: scramble data so no stale pair looks held
  task idle;
    begin
      inValid = 1'b0;
      inI = ~inI;
      inQ = ~inQ;
    end
  endtask
endmodule
